// *** common/drive_io_pkg.sv ***
// Package for the drive terminal conditioning block: map, layouts, timing
package drive_io_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_POL_A = 8'h00;
  localparam logic [7:0] OFS_POL_B = 8'h04;
  localparam logic [7:0] OFS_AIN2_KIND = 8'h08;
  localparam logic [7:0] OFS_DELAY_ONE = 8'h0c;
  localparam logic [7:0] OFS_DELAY_TWO = 8'h10;
  localparam logic [7:0] OFS_DELAY_THREE = 8'h14;
  localparam logic [7:0] OFS_OUT_SEL = 8'h18;
  localparam logic [7:0] OFS_PRESET_COUNT = 8'h1c;
  localparam logic [7:0] OFS_DESIG_COUNT = 8'h20;
  localparam logic [7:0] OFS_LENGTH = 8'h24;
  localparam logic [7:0] OFS_RUN_LIMIT = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;

  // Reset values
  localparam logic [15:0] POL_RESET = 16'h0000;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Sizes and field layout
  localparam int NUM_IN = 10;
  localparam int NUM_DELAYED = 3;
  localparam int NUM_OUT = 4;
  localparam int SEL_W = 8;
  localparam int DIGITS = 5;
  localparam int STAT_TERM_LSB = 16;

  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int DELAY_UNIT_MS = 100;
  localparam int PULSE_MS = 250;
  localparam int TENTH_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;
  localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
  localparam int OVL_LEAD_S = 10;
  localparam logic [15:0] OVL_LEAD_TENTHS = 16'(OVL_LEAD_S * 1000 / DELAY_UNIT_MS);

  // Output terminal functions
  typedef enum logic [SEL_W-1:0] {
    FN_NONE = 8'h00, FN_RUNNING = 8'h01, FN_FAULT_STOP = 8'h02,
    FN_ZERO_SPEED = 8'h05, FN_MOTOR_OVL = 8'h06, FN_DRIVE_OVL = 8'h07,
    FN_PRESET_COUNT = 8'h08, FN_DESIG_COUNT = 8'h09, FN_LENGTH = 8'h0a,
    FN_SEQ_DONE = 8'h0b, FN_RUN_TIME = 8'h0c, FN_FREQ_LIMITED = 8'h0d,
    FN_TORQUE_LIMIT = 8'h0e, FN_READY = 8'h0f, FN_AIN1_GT_AIN2 = 8'h10,
    FN_UPPER_LIMIT = 8'h11, FN_LOWER_LIMIT = 8'h12
  } out_fn_t;

  // Status conditions from the drive core
  typedef struct packed {
    logic running;
    logic fault_stop;
    logic out_freq_zero;
    logic motor_ovl_warn;
    logic drive_ovl_active;
    logic [15:0] drive_ovl_left_tenths;
    logic [31:0] count_value;
    logic [31:0] length_value;
    logic [31:0] run_time;
    logic seq_cycle_done;
    logic set_freq_beyond;
    logic out_at_limit;
    logic speed_ctrl;
    logic torque_stall;
    logic ready;
    logic [15:0] first_analog_channel;
    logic [15:0] second_analog_channel;
    logic at_upper_limit;
    logic at_lower_limit;
  } drive_status_t;

  // Decimal-digit polarity decode: nonzero digit selects active-low
  function automatic logic [DIGITS-1:0] digit_flags(input logic [15:0] v);
    logic [15:0] rest;
    logic [DIGITS-1:0] f;
    rest = v;
    f = '0;
    for (int i = 0; i < DIGITS; i++) begin
      f[i] = (rest % 16'd10) != 16'd0;
      rest = rest / 16'd10;
    end
    return f;
  endfunction

endpackage

// *** rtl/drive_terminal_io_logic.sv ***
// Switch input conditioning, output terminal selection and APB register file
// Function
// RQ1 - Change delay on switch inputs one to three
// RQ2 - Low group digits set inputs one-five polarity
// RQ3 - High group digits set inputs six-ten polarity
// RQ4 - Polarity settings reset to zero, active-high
// RQ5 - Active-high: closed to return means asserted
// RQ6 - Active-low: closed to return means deasserted
// RQ7 - Channel two kind: zero voltage, one current
// RQ8 - Selector zero keeps terminal inactive
// RQ9 - Selector one: on while running
// RQ10 - Selector two: on when stopped by fault
// RQ11 - Selector five: running at zero frequency
// RQ12 - Selector six: motor overload pre-warning
// RQ13 - Selector seven: ten seconds before overload trip
// RQ14 - Selectors eight/nine: count reaches its target
// RQ15 - Selector ten: length exceeds target
// RQ16 - Selector eleven: 250 ms pulse per cycle
// RQ17 - Selector twelve: run time exceeds limit
// RQ18 - Selector thirteen: frequency held at limit
// RQ19 - Selector fourteen: torque limit stall, speed control
// RQ20 - Selector fifteen: ready to run
// RQ21 - Selector sixteen: channel one above two
// RQ22 - Selector seventeen: at upper frequency limit
// RQ23 - Selector eighteen: lower limit, off when stopped
// RQ24 - Polarity first, then delay stage
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module input_change_delay (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timebase and setting
  input wire logic tick,
  input wire logic [15:0] delay_tenths,
  // Level in and out
  input wire logic level_in,
  output logic level_out
);

  logic [15:0] wait_q;
  logic out_q;

  // New level accepted only after it held for the full delay
  // A return to the old level restarts the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= '0;
      out_q <= 1'b0;
    end else if (level_in == out_q) begin
      wait_q <= '0;
    end else if (wait_q >= delay_tenths) begin // see RQ1
      out_q <= level_in;
      wait_q <= '0;
    end else if (tick) begin
      wait_q <= wait_q + 16'h0001;
    end
  end

  assign level_out = out_q;

endmodule // input_change_delay

module drive_terminal_io_logic #(
  parameter int TENTH_CYCLES = drive_io_pkg::TENTH_CYCLES,
  parameter int PULSE_CYCLES = drive_io_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field contacts, 1 while tied to the shared return terminal
  input wire logic [drive_io_pkg::NUM_IN-1:0] switch_in,
  // Drive status sources
  input wire drive_io_pkg::drive_status_t drive_status,
  // Conditioned inputs toward the drive
  output logic [drive_io_pkg::NUM_IN-1:0] switch_state,
  // Output terminals, 1 means ON
  output logic [drive_io_pkg::NUM_OUT-1:0] out_terminal,
  // Second analog channel front end: 1 selects current
  output logic second_channel_kind_sel
);

  localparam int TW = $clog2(TENTH_CYCLES + 1);
  localparam int PW = $clog2(PULSE_CYCLES + 1);

  // Register file
  logic [15:0] polarity_select_low_group_q;
  logic [15:0] polarity_select_high_group_q;
  logic kind_q;
  logic [15:0] delay_q [drive_io_pkg::NUM_DELAYED];
  logic [drive_io_pkg::NUM_OUT*drive_io_pkg::SEL_W-1:0] out_sel_q;
  logic [31:0] preset_count_target_q;
  logic [31:0] designated_count_target_q;
  logic [31:0] length_target_q;
  logic [31:0] run_time_limit_q;

  // Bus handshake
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic wr_en;
  logic [31:0] rd_d;
  logic hit;

  // Timebases
  logic [TW-1:0] tenth_cnt_q;
  logic tick_q;
  logic [PW-1:0] pulse_cnt_q;
  logic pulse_on;

  // Input path
  logic [drive_io_pkg::NUM_IN-1:0] active_low;
  logic [drive_io_pkg::NUM_IN-1:0] logical_in;
  logic [drive_io_pkg::NUM_IN-1:0] conditioned;
  logic [drive_io_pkg::NUM_IN-1:0] switch_state_q;

  // Output path
  logic [drive_io_pkg::NUM_OUT-1:0] term_d;
  logic [drive_io_pkg::NUM_OUT-1:0] term_q;
  logic kind_out_q;

  // APB: one wait state, answer on second access cycle
  assign access = psel && penable;
  assign wr_en = access && pwrite && pready_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access && !pready_q;
    end
  end

  // Read decode
  // Unmapped offsets read zero and raise an error
  always_comb begin
    rd_d = '0;
    hit = 1'b1;
    case (paddr)
      drive_io_pkg::OFS_POL_A: rd_d[15:0] = polarity_select_low_group_q;
      drive_io_pkg::OFS_POL_B: rd_d[15:0] = polarity_select_high_group_q;
      drive_io_pkg::OFS_AIN2_KIND: rd_d[0] = kind_q;
      drive_io_pkg::OFS_DELAY_ONE: rd_d[15:0] = delay_q[0];
      drive_io_pkg::OFS_DELAY_TWO: rd_d[15:0] = delay_q[1];
      drive_io_pkg::OFS_DELAY_THREE: rd_d[15:0] = delay_q[2];
      drive_io_pkg::OFS_OUT_SEL: rd_d = out_sel_q;
      drive_io_pkg::OFS_PRESET_COUNT: rd_d = preset_count_target_q;
      drive_io_pkg::OFS_DESIG_COUNT: rd_d = designated_count_target_q;
      drive_io_pkg::OFS_LENGTH: rd_d = length_target_q;
      drive_io_pkg::OFS_RUN_LIMIT: rd_d = run_time_limit_q;
      drive_io_pkg::OFS_STATUS: begin
        rd_d[drive_io_pkg::NUM_IN-1:0] = switch_state_q;
        rd_d[drive_io_pkg::STAT_TERM_LSB +: drive_io_pkg::NUM_OUT] = term_q;
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (access && !pready_q) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr_q <= !hit || (pwrite && paddr == drive_io_pkg::OFS_STATUS);
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // Polarity settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polarity_select_low_group_q <= drive_io_pkg::POL_RESET; // see RQ4
      polarity_select_high_group_q <= drive_io_pkg::POL_RESET; // see RQ4
    end else if (wr_en && paddr == drive_io_pkg::OFS_POL_A) begin
      polarity_select_low_group_q <= pwdata[15:0];
    end else if (wr_en && paddr == drive_io_pkg::OFS_POL_B) begin
      polarity_select_high_group_q <= pwdata[15:0];
    end
  end

  // Second channel kind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_q <= 1'b0;
    end else if (wr_en && paddr == drive_io_pkg::OFS_AIN2_KIND) begin
      kind_q <= pwdata[0]; // see RQ7
    end
  end

  // Delay settings, tenths of a second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_q[0] <= drive_io_pkg::DELAY_RESET;
      delay_q[1] <= drive_io_pkg::DELAY_RESET;
      delay_q[2] <= drive_io_pkg::DELAY_RESET;
    end else if (wr_en) begin
      if (paddr == drive_io_pkg::OFS_DELAY_ONE) begin
        delay_q[0] <= pwdata[15:0];
      end
      if (paddr == drive_io_pkg::OFS_DELAY_TWO) begin
        delay_q[1] <= pwdata[15:0];
      end
      if (paddr == drive_io_pkg::OFS_DELAY_THREE) begin
        delay_q[2] <= pwdata[15:0];
      end
    end
  end

  // Terminal selectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sel_q <= '0;
    end else if (wr_en && paddr == drive_io_pkg::OFS_OUT_SEL) begin
      out_sel_q <= pwdata;
    end
  end

  // Count, length and run-time targets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_count_target_q <= drive_io_pkg::WORD_RESET;
      designated_count_target_q <= drive_io_pkg::WORD_RESET;
      length_target_q <= drive_io_pkg::WORD_RESET;
      run_time_limit_q <= drive_io_pkg::WORD_RESET;
    end else if (wr_en) begin
      case (paddr)
        drive_io_pkg::OFS_PRESET_COUNT: preset_count_target_q <= pwdata;
        drive_io_pkg::OFS_DESIG_COUNT: designated_count_target_q <= pwdata;
        drive_io_pkg::OFS_LENGTH: length_target_q <= pwdata;
        drive_io_pkg::OFS_RUN_LIMIT: run_time_limit_q <= pwdata;
        default: ;
      endcase
    end
  end

  // Tenth-second tick for the change delay
  // Free running, so the first tick of a wait may come early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tenth_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tenth_cnt_q == TW'(TENTH_CYCLES - 1)) begin
      tenth_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tenth_cnt_q <= tenth_cnt_q + TW'(1);
      tick_q <= 1'b0;
    end
  end

  // Polarity: digit per input, low group then high group
  assign active_low = {drive_io_pkg::digit_flags(polarity_select_high_group_q), // see RQ3
                       drive_io_pkg::digit_flags(polarity_select_low_group_q)}; // see RQ2
  assign logical_in = switch_in ^ active_low; // see RQ5 see RQ6 see RQ24

  // Delay stage on the first three inputs only
  for (genvar i = 0; i < drive_io_pkg::NUM_DELAYED; i++) begin : g_delay
    input_change_delay u_delay (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_q),
      .delay_tenths(delay_q[i]),
      .level_in(logical_in[i]),
      .level_out(conditioned[i])
    ); // see RQ1 see RQ24
  end
  // Inputs four to ten pass straight through
  assign conditioned[drive_io_pkg::NUM_IN-1:drive_io_pkg::NUM_DELAYED] =
    logical_in[drive_io_pkg::NUM_IN-1:drive_io_pkg::NUM_DELAYED];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_state_q <= '0;
    end else begin
      switch_state_q <= conditioned;
    end
  end

  // Sequence-cycle pulse, restarted by each completion
  // Runs whatever the selectors hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_q <= '0;
    end else if (drive_status.seq_cycle_done) begin
      pulse_cnt_q <= PW'(PULSE_CYCLES); // see RQ16
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - PW'(1);
    end
  end
  assign pulse_on = pulse_cnt_q != '0;

  // Terminal function selection
  always_comb begin
    drive_io_pkg::out_fn_t fn;
    fn = drive_io_pkg::FN_NONE;
    term_d = '0;
    for (int t = 0; t < drive_io_pkg::NUM_OUT; t++) begin
      fn = drive_io_pkg::out_fn_t'(out_sel_q[t*drive_io_pkg::SEL_W +: drive_io_pkg::SEL_W]);
      case (fn)
        drive_io_pkg::FN_NONE: term_d[t] = 1'b0; // see RQ8
        drive_io_pkg::FN_RUNNING: term_d[t] = drive_status.running; // see RQ9
        drive_io_pkg::FN_FAULT_STOP: term_d[t] = drive_status.fault_stop; // see RQ10
        drive_io_pkg::FN_ZERO_SPEED:
          term_d[t] = drive_status.running && drive_status.out_freq_zero; // see RQ11
        drive_io_pkg::FN_MOTOR_OVL: term_d[t] = drive_status.motor_ovl_warn; // see RQ12
        drive_io_pkg::FN_DRIVE_OVL:
          term_d[t] = drive_status.drive_ovl_active &&
            drive_status.drive_ovl_left_tenths <= drive_io_pkg::OVL_LEAD_TENTHS; // see RQ13
        drive_io_pkg::FN_PRESET_COUNT:
          term_d[t] = drive_status.count_value >= preset_count_target_q; // see RQ14
        drive_io_pkg::FN_DESIG_COUNT:
          term_d[t] = drive_status.count_value >= designated_count_target_q; // see RQ14
        drive_io_pkg::FN_LENGTH:
          term_d[t] = drive_status.length_value > length_target_q; // see RQ15
        drive_io_pkg::FN_SEQ_DONE: term_d[t] = pulse_on; // see RQ16
        drive_io_pkg::FN_RUN_TIME:
          term_d[t] = drive_status.run_time > run_time_limit_q; // see RQ17
        drive_io_pkg::FN_FREQ_LIMITED:
          term_d[t] = drive_status.set_freq_beyond && drive_status.out_at_limit; // see RQ18
        drive_io_pkg::FN_TORQUE_LIMIT:
          term_d[t] = drive_status.speed_ctrl && drive_status.torque_stall; // see RQ19
        drive_io_pkg::FN_READY: term_d[t] = drive_status.ready; // see RQ20
        drive_io_pkg::FN_AIN1_GT_AIN2:
          term_d[t] = drive_status.first_analog_channel >
            drive_status.second_analog_channel; // see RQ21
        drive_io_pkg::FN_UPPER_LIMIT: term_d[t] = drive_status.at_upper_limit; // see RQ22
        drive_io_pkg::FN_LOWER_LIMIT:
          term_d[t] = drive_status.running && drive_status.at_lower_limit; // see RQ23
        default: term_d[t] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_q <= '0;
    end else begin
      term_q <= term_d;
    end
  end

  // Front-end kind select follows the register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_out_q <= 1'b0;
    end else begin
      kind_out_q <= kind_q; // see RQ7
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign switch_state = switch_state_q;
  assign out_terminal = term_q;
  assign second_channel_kind_sel = kind_out_q;

endmodule // drive_terminal_io_logic

`default_nettype wire

// *** test/drive_terminal_io_logic_monitor.sv ***
// Concurrent checks on the terminal block ports
`timescale 1ns/1ps
`default_nettype none
module drive_terminal_io_logic_monitor #(
  parameter int PULSE_CYCLES = 10
) (
  // Clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Terminals
  input wire logic [drive_io_pkg::NUM_IN-1:0] switch_in,
  input wire drive_io_pkg::drive_status_t drive_status,
  input wire logic [drive_io_pkg::NUM_IN-1:0] switch_state,
  input wire logic [drive_io_pkg::NUM_OUT-1:0] out_terminal,
  input wire logic second_channel_kind_sel
);
  logic [7:0] sel_q;
  logic [7:0] cnt_q;
  logic wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 8'h00;
    end else if (wr_done && paddr == drive_io_pkg::OFS_OUT_SEL) begin
      sel_q <= pwdata[7:0];
    end
  end
  // Cycles since a sequence-done pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else if (drive_status.seq_cycle_done && sel_q == 8'h0b) begin
      cnt_q <= 8'h01;
    end else if (cnt_q != 8'h00 && cnt_q <= 8'(PULSE_CYCLES + 1)) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      cnt_q <= 8'h00;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_KIND: assert property (
    wr_done && paddr == drive_io_pkg::OFS_AIN2_KIND |->
    ##2 second_channel_kind_sel == $past(pwdata[0], 2))
    else $error("kind output not updated");
  AST_STATUS_RO: assert property (wr_done && paddr == drive_io_pkg::OFS_STATUS |-> pslverr)
    else $error("status write not refused");
  AST_SEL_NONE: assert property (sel_q == 8'h00 |=> !out_terminal[0])
    else $error("idle terminal active");
  AST_SEL_RUN: assert property (
    sel_q == 8'h01 |=> out_terminal[0] == $past(drive_status.running))
    else $error("running terminal wrong");
  AST_SEL_ZERO: assert property (sel_q == 8'h05 |=>
    out_terminal[0] == $past(drive_status.running && drive_status.out_freq_zero))
    else $error("zero speed terminal wrong");
  AST_SEL_OVL: assert property (sel_q == 8'h07 |=> out_terminal[0] ==
    $past(drive_status.drive_ovl_active && drive_status.drive_ovl_left_tenths <= 16'h0064))
    else $error("overload lead terminal wrong");
  AST_PULSE_ON: assert property (
    sel_q == 8'h0b && cnt_q >= 8'h02 && cnt_q <= 8'(PULSE_CYCLES + 1) |-> out_terminal[0])
    else $error("pulse too short");
  AST_PULSE_OFF: assert property (
    sel_q == 8'h0b && cnt_q == 8'(PULSE_CYCLES + 2) |-> !out_terminal[0])
    else $error("pulse too long");
endmodule // drive_terminal_io_logic_monitor
`default_nettype wire

// *** test/field_wiring_model.sv ***
// Field contacts and analog jumper wiring
`timescale 1ns/1ps
`default_nettype none
module field_wiring_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commanded closures and jumper
  input wire logic [drive_io_pkg::NUM_IN-1:0] closed,
  input wire logic jumper_current,
  input wire logic second_channel_kind_sel,
  // Toward the block
  output logic [drive_io_pkg::NUM_IN-1:0] switch_in,
  output logic jumper_ok
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_in <= '0;
    end else begin
      switch_in <= closed;
    end
  end
  assign jumper_ok = jumper_current == second_channel_kind_sel;
endmodule // field_wiring_model
`default_nettype wire

// *** test/drive_terminal_io_logic_tb_top.sv ***
// Self-checking bench for the terminal block
`timescale 1ns/1ps
`default_nettype none
module drive_terminal_io_logic_tb_top;
  localparam int PULSE_P = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, kind, jmp, jok, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, tg [4];
  logic [9:0] closed, sw_in, sw_st, fl;
  logic [3:0] out_t, ev;
  logic [7:0] sel [4];
  logic [7:0] codes [16] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
    8'h0a, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12};
  drive_io_pkg::drive_status_t st;
  int num_errors, num_checks, n;
  drive_terminal_io_logic #(.TENTH_CYCLES(4), .PULSE_CYCLES(PULSE_P)) drive_terminal_io_logic_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_in(sw_in), .drive_status(st), .switch_state(sw_st), .out_terminal(out_t),
    .second_channel_kind_sel(kind));
  field_wiring_model field_wiring_model_i (.pclk(pclk), .presetn(presetn), .closed(closed),
    .jumper_current(jmp), .second_channel_kind_sel(kind), .switch_in(sw_in), .jumper_ok(jok));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(int c);
    repeat (c) @(posedge pclk);
  endtask
  function automatic logic [15:0] dec(logic [4:0] b);
    dec = 16'h0000;
    for (int k = 4; k >= 0; k--) dec = dec * 16'h000a + 16'(b[k]);
  endfunction
  function automatic logic ex(logic [7:0] c, drive_io_pkg::drive_status_t s);
    case (c)
      8'h01: ex = s.running;
      8'h02: ex = s.fault_stop;
      8'h05: ex = s.running && s.out_freq_zero;
      8'h06: ex = s.motor_ovl_warn;
      8'h07: ex = s.drive_ovl_active && s.drive_ovl_left_tenths <= 16'h0064;
      8'h08: ex = s.count_value >= tg[0];
      8'h09: ex = s.count_value >= tg[1];
      8'h0a: ex = s.length_value > tg[2];
      8'h0c: ex = s.run_time > tg[3];
      8'h0d: ex = s.set_freq_beyond && s.out_at_limit;
      8'h0e: ex = s.speed_ctrl && s.torque_stall;
      8'h0f: ex = s.ready;
      8'h10: ex = s.first_analog_channel > s.second_analog_channel;
      8'h11: ex = s.at_upper_limit;
      8'h12: ex = s.at_lower_limit && s.running;
      default: ex = 1'b0;
    endcase
  endfunction
  task automatic rnd_st();
    drive_io_pkg::drive_status_t s;
    logic [159:0] r;
    r = {$urandom, $urandom, $urandom, $urandom, $urandom};
    s = r[$bits(s)-1:0];
    s.count_value = 32'($urandom_range(15));
    s.length_value = 32'($urandom_range(15));
    s.run_time = 32'($urandom_range(15));
    s.drive_ovl_left_tenths = 16'($urandom_range(200));
    s.seq_cycle_done = 1'b0;
    @(posedge pclk);
    st <= s;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #750000;
    num_errors++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, closed, jmp, st} = '0;
    presetn = 1'b0;
    void'($urandom(32'hcaae6fbe));
    wt(20);
    presetn <= 1'b1;
    apb(1'b0, drive_io_pkg::OFS_POL_A, 0);
    chk("pol_a", 0, rd);
    apb(1'b0, drive_io_pkg::OFS_POL_B, 0);
    chk("pol_b", 0, rd);
    apb(1'b0, 8'h30, 0);
    chk("unmapped", 1, 32'(err));
    apb(1'b1, drive_io_pkg::OFS_STATUS, 32'hffff_ffff);
    chk("ro", 1, 32'(err));
    @(posedge pclk);
    closed <= 10'h2b5;
    wt(6);
    chk("active high", 32'h2b5, 32'(sw_st));
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      fl = (i == 0) ? 10'h3ff : 10'($urandom);
      apb(1'b1, drive_io_pkg::OFS_POL_A, 32'(dec(fl[4:0])));
      apb(1'b1, drive_io_pkg::OFS_POL_B, 32'(dec(fl[9:5])));
      @(posedge pclk);
      closed <= 10'($urandom);
      wt(8);
      chk("state", 32'(closed ^ fl), 32'(sw_st));
      apb(1'b0, drive_io_pkg::OFS_STATUS, 0);
      chk("status", 32'(closed ^ fl), 32'(rd[9:0]));
    end
    $display("test polarity done");
    apb(1'b1, drive_io_pkg::OFS_POL_A, 0);
    apb(1'b1, drive_io_pkg::OFS_POL_B, 0);
    for (int i = 0; i < 3; i++) apb(1'b1, 8'(drive_io_pkg::OFS_DELAY_ONE + 4 * i), 3);
    @(posedge pclk);
    closed <= 10'h000;
    wt(30);
    closed <= 10'h00f;
    wt(6);
    chk("early", 32'h8, 32'(sw_st & 10'h00f));
    wt(20);
    chk("late", 32'hf, 32'(sw_st & 10'h00f));
    $display("test delay done");
    for (int i = 0; i < 4; i++) begin
      tg[i] = 32'($urandom_range(15));
      apb(1'b1, 8'(drive_io_pkg::OFS_PRESET_COUNT + 4 * i), tg[i]);
    end
    foreach (codes[j]) begin
      for (int t = 0; t < 4; t++) sel[t] = codes[(j + t) % 16];
      apb(1'b1, drive_io_pkg::OFS_OUT_SEL, {sel[3], sel[2], sel[1], sel[0]});
      repeat (6) begin
        rnd_st();
        wt(2);
        for (int t = 0; t < 4; t++) ev[t] = ex(sel[t], st);
        chk("terminal", 32'(ev), 32'(out_t));
      end
    end
    $display("test select done");
    apb(1'b1, drive_io_pkg::OFS_OUT_SEL, 32'h0b0b_0b0b);
    @(posedge pclk);
    st <= '0;
    @(posedge pclk);
    st.seq_cycle_done <= 1'b1;
    @(posedge pclk);
    st.seq_cycle_done <= 1'b0;
    n = 0;
    repeat (30) begin
      @(posedge pclk);
      if (out_t[0] === 1'b1) n++;
    end
    chk("pulse", PULSE_P, 32'(n));
    $display("test pulse done");
    jmp <= 1'b1;
    apb(1'b1, drive_io_pkg::OFS_AIN2_KIND, 1);
    wt(2);
    chk("kind", 1, 32'(kind));
    chk("jumper", 1, 32'(jok));
    jmp <= 1'b0;
    apb(1'b1, drive_io_pkg::OFS_AIN2_KIND, 32'h2);
    apb(1'b0, drive_io_pkg::OFS_AIN2_KIND, 0);
    chk("kind rd", 0, rd);
    chk("jumper", 1, 32'(jok));
    $display("test kind done");
    close_out();
  end
endmodule // drive_terminal_io_logic_tb_top
bind drive_terminal_io_logic drive_terminal_io_logic_monitor #(.PULSE_CYCLES(PULSE_CYCLES))
  drive_terminal_io_logic_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .switch_in(switch_in), .drive_status(drive_status),
  .switch_state(switch_state), .out_terminal(out_terminal),
  .second_channel_kind_sel(second_channel_kind_sel));
`default_nettype wire
